/* File: pci_pkg.sv */
// Shared constants for the multiplexed address/data bus pair.
// Assumes both ends run on one clock and meet through pci_link.
package pci_pkg;
	localparam int ad_width = 32; // Address/data lines
	localparam int cbe_width = 4; // Command/byte-enable lines
	localparam int fifo_depth_default = 8; // Data path buffer words
	localparam logic [3:0] cmd_io_read = 4'h2; // Bus command codes
	localparam logic [3:0] cmd_io_write = 4'h3;
	localparam logic [3:0] cmd_mem_read = 4'h6;
	localparam logic [3:0] cmd_mem_write = 4'h7;
	localparam logic [3:0] cmd_cfg_read = 4'ha;
	localparam logic [3:0] cmd_cfg_write = 4'hb;
	localparam logic [31:0] ad_reset = 32'h0; // Bus value after reset
	localparam logic [3:0] be_none_n = 4'hf; // No lane enabled (active low)
	localparam int lane_lsb_hi = 7; // Byte lane 0 top bit
	localparam int lane_msb_lo = 24; // Byte lane 3 bottom bit
	localparam int dword_shift = 2; // Byte address to word index
endpackage

/* File: pci_link.sv */
// Bus wires between initiator and target ends.
// Assumes the testbench resolves shared lines from the enables.
`timescale 1ns/100ps
`default_nettype none
interface pci_link;
	logic [31:0] ad_m; // Initiator address/data drive
	logic ad_m_oe; // Initiator drives AD
	logic [31:0] ad_t; // Target read data drive
	logic ad_t_oe; // Target drives AD
	logic [31:0] ad_in; // Resolved AD level
	logic [3:0] cbe_n; // Command/byte enables, active low
	logic par_m; // Initiator parity
	logic par_m_oe;
	logic par_t; // Target parity
	logic par_t_oe;
	logic par_in; // Resolved parity level
	logic frame_n; // Transaction frame, active low
	logic irdy_n; // Initiator ready, active low
	logic trdy_n; // Target ready, active low
	logic stop_n; // Target stop request, active low
	modport initiator (output ad_m, output ad_m_oe, input ad_in, output cbe_n,
		output par_m, output par_m_oe, input par_in, output frame_n,
		output irdy_n, input trdy_n, input stop_n);
	modport target (output ad_t, output ad_t_oe, input ad_in, input cbe_n,
		output par_t, output par_t_oe, input par_in, input frame_n,
		input irdy_n, output trdy_n, output stop_n);
endinterface
`default_nettype wire

/* File: pci_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
`timescale 1ns/100ps
`default_nettype none
module pci_fifo #(
	parameter int width = 32,
	parameter int depth = 8
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem [depth]; // Storage words
	logic [aw-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd; // Pointers
	logic [aw:0] cnt_ff, nxt_cnt; // Fill level
	logic push, pop;
	//////////////////////////////////////////////////////////////////
	// Pointer and level update
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		nxt_wr = push ? ((wr_ff == aw'(depth - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
		nxt_rd = pop ? ((rd_ff == aw'(depth - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
		nxt_cnt = cnt_ff + (aw+1)'(push) - (aw+1)'(pop);
	end
	// Registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end
	// Storage needs no reset
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ff] <= in_data;
		end
	end
	assign in_ready = cnt_ff != (aw+1)'(depth); // Honest full
	assign out_valid = cnt_ff != '0; // Honest empty
	assign out_data = mem[rd_ff];
endmodule
`default_nettype wire

/* File: pci_target.sv */
// Target end: hands writes to the user through one register, answers reads from a buffer.
// Assumes pci_link carries the bus and the initiator keeps its part.
`timescale 1ns/100ps
`default_nettype none
module pci_target import pci_pkg::*; #(
	parameter int depth = fifo_depth_default
) (
	input wire logic mclk,
	input wire logic sys_rst,
	pci_link.target bus,
	output logic wr_valid, // Write word out to user
	input wire logic wr_ready,
	output logic [31:0] wr_data,
	output logic [3:0] wr_be, // Active high lane enables
	output logic [31:0] wr_addr,
	input wire logic rd_valid, // Read word from user
	output logic rd_ready,
	input wire logic [31:0] rd_data,
	input wire logic stop_req // User asks to end transaction
);
	typedef enum logic [1:0] {t_idle, t_data} tstate_e;
	tstate_e st_ff, nxt_st;
	logic is_read_ff, nxt_is_read; // Current command is a read
	logic [31:0] addr_ff, nxt_addr; // Address of current word
	logic trdy_ff, nxt_trdy; // Ready strobe (active high inside)
	logic stop_ff, nxt_stop;
	logic [31:0] ad_ff, nxt_ad;
	logic ad_oe_ff, nxt_ad_oe;
	logic par_ff, nxt_par, par_oe_ff, nxt_par_oe;
	logic wv_ff, nxt_wv;
	logic [31:0] wd_ff, nxt_wd, wa_ff, nxt_wa;
	logic [3:0] wbe_ff, nxt_wbe;
	logic frame_d_ff; // Frame seen last clock
	logic xfer; // Word completes this edge
	logic fifo_in_ready, fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic fifo_pop;
	//////////////////////////////////////////////////////////////////
	// Read data buffer; back-pressure reaches user via rd_ready
	pci_fifo #(.width(32), .depth(depth)) rd_buf (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(rd_valid),
		.in_ready(fifo_in_ready),
		.in_data(rd_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);
	assign rd_ready = fifo_in_ready;
	//////////////////////////////////////////////////////////////////
	// Phase tracking and handshake
	always_comb begin
		xfer = !bus.irdy_n && trdy_ff;
		fifo_pop = 1'b0;
		nxt_st = st_ff;
		nxt_is_read = is_read_ff;
		nxt_addr = addr_ff;
		nxt_trdy = 1'b0;
		nxt_stop = stop_ff;
		nxt_ad = ad_ff;
		nxt_ad_oe = 1'b0;
		nxt_wv = wv_ff && !wr_ready;
		nxt_wd = wd_ff;
		nxt_wa = wa_ff;
		nxt_wbe = wbe_ff;
		case (st_ff)
			t_idle: begin
				nxt_stop = 1'b0;
				// First clock with frame asserted is the address phase
				if (!bus.frame_n && frame_d_ff) begin
					nxt_is_read = !bus.cbe_n[0]; // Even codes read
					// I/O keeps byte address; others word aligned
					if (bus.cbe_n[3:1] == cmd_io_read[3:1]) begin
						nxt_addr = bus.ad_in;
					end else begin
						nxt_addr = {bus.ad_in[31:dword_shift], 2'b00};
					end
					nxt_st = t_data;
				end
			end
			t_data: begin
				if (xfer) begin
					if (is_read_ff) begin
						fifo_pop = 1'b1;
					end else begin
						nxt_wv = 1'b1;
						nxt_wd = bus.ad_in;
						nxt_wbe = ~bus.cbe_n;
						nxt_wa = addr_ff;
					end
					nxt_addr = addr_ff + 32'h4;
				end
				if (stop_req) begin
					nxt_stop = 1'b1;
				end
				// Frame released and word taken: transaction over
				if (xfer && bus.frame_n) begin
					nxt_st = t_idle;
				end else begin
					// Reads: ready only with data; writes: only with room
					if (is_read_ff) begin
						// Drop for one clock after a word so the next one can load
						nxt_trdy = fifo_out_valid && !xfer;
						nxt_ad_oe = 1'b1;
						nxt_ad = xfer ? ad_ff : fifo_out_data;
					end else begin
						nxt_trdy = !nxt_wv;
					end
					// Wait states until both strobes meet
					if (trdy_ff && !xfer) begin
						nxt_trdy = 1'b1;
						nxt_ad = ad_ff;
					end
				end
			end
			default: nxt_st = t_idle;
		endcase
	end
	// Registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_ff <= t_idle;
			is_read_ff <= 1'b0;
			addr_ff <= ad_reset;
			trdy_ff <= 1'b0;
			stop_ff <= 1'b0;
			ad_ff <= ad_reset;
			ad_oe_ff <= 1'b0;
			wv_ff <= 1'b0;
			wd_ff <= ad_reset;
			wa_ff <= ad_reset;
			wbe_ff <= 4'h0;
			frame_d_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			is_read_ff <= nxt_is_read;
			addr_ff <= nxt_addr;
			trdy_ff <= nxt_trdy;
			stop_ff <= nxt_stop;
			ad_ff <= nxt_ad;
			ad_oe_ff <= nxt_ad_oe;
			wv_ff <= nxt_wv;
			wd_ff <= nxt_wd;
			wa_ff <= nxt_wa;
			wbe_ff <= nxt_wbe;
			frame_d_ff <= bus.frame_n;
		end
	end
	//////////////////////////////////////////////////////////////////
	// Read parity trails read data by one clock
	always_comb begin
		nxt_par_oe = ad_oe_ff;
		nxt_par = ^{ad_ff, bus.cbe_n};
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			par_ff <= 1'b0;
			par_oe_ff <= 1'b0;
		end else begin
			par_ff <= nxt_par;
			par_oe_ff <= nxt_par_oe;
		end
	end
	assign bus.ad_t = ad_ff;
	assign bus.ad_t_oe = ad_oe_ff;
	assign bus.par_t = par_ff;
	assign bus.par_t_oe = par_oe_ff;
	assign bus.trdy_n = !trdy_ff;
	assign bus.stop_n = !stop_ff;
	assign wr_valid = wv_ff;
	assign wr_data = wd_ff;
	assign wr_be = wbe_ff;
	assign wr_addr = wa_ff;
endmodule
`default_nettype wire

/* File: pci_initiator.sv */
// Initiator end: runs one burst per user command.
`timescale 1ns/100ps
`default_nettype none
module pci_initiator import pci_pkg::*; #(
	parameter int len_width = 8
) (
	input wire logic mclk,
	input wire logic sys_rst,
	pci_link.initiator bus,
	input wire logic cmd_valid, // Start a burst
	output logic cmd_ready,
	input wire logic [3:0] cmd_code,
	input wire logic [31:0] cmd_addr,
	input wire logic [len_width-1:0] cmd_len, // Words minus one
	input wire logic [3:0] cmd_be, // Active high lane enables
	input wire logic [31:0] wdata, // Write word from user
	input wire logic wdata_valid,
	output logic wdata_ready,
	output logic rdata_valid, // Read word to user
	output logic [31:0] rdata,
	output logic done // Burst ended, one-cycle pulse
);
	typedef enum logic [1:0] {m_idle, m_addr, m_data} mstate_e;
	mstate_e st_ff, nxt_st;
	logic [31:0] ad_ff, nxt_ad;
	logic ad_oe_ff, nxt_ad_oe;
	logic [3:0] cbe_ff, nxt_cbe;
	logic frame_ff, nxt_frame, irdy_ff, nxt_irdy;
	logic is_read_ff, nxt_is_read;
	logic [len_width-1:0] left_ff, nxt_left;
	logic par_ff, nxt_par, par_oe_ff, nxt_par_oe;
	logic rv_ff, nxt_rv, done_ff, nxt_done, wr_ff, nxt_wr;
	logic [31:0] rd_ff, nxt_rd;
	logic xfer;
	logic idle_ff, nxt_idle; // Idle copy so cmd_ready comes from a flop
	//////////////////////////////////////////////////////////////////
	// Burst sequencer
	always_comb begin
		xfer = irdy_ff && !bus.trdy_n;
		nxt_st = st_ff;
		nxt_ad = ad_ff;
		nxt_ad_oe = ad_oe_ff;
		nxt_cbe = cbe_ff;
		nxt_frame = frame_ff;
		nxt_irdy = irdy_ff;
		nxt_is_read = is_read_ff;
		nxt_left = left_ff;
		nxt_rv = 1'b0;
		nxt_rd = rd_ff;
		nxt_done = 1'b0;
		nxt_wr = 1'b0;
		case (st_ff)
			m_idle: begin
				if (cmd_valid) begin
					nxt_frame = 1'b1;
					nxt_ad = cmd_addr;
					nxt_ad_oe = 1'b1;
					nxt_cbe = cmd_code;
					nxt_is_read = !cmd_code[0];
					nxt_left = cmd_len;
					nxt_st = m_addr;
				end
			end
			m_addr: begin
				nxt_cbe = ~cmd_be;
				nxt_ad_oe = !is_read_ff;
				nxt_st = m_data;
				if (left_ff == '0) begin
					nxt_frame = 1'b0;
				end
				if (is_read_ff) begin
					nxt_irdy = 1'b1;
				end else if (wdata_valid) begin
					nxt_ad = wdata;
					nxt_irdy = 1'b1;
					nxt_wr = 1'b1;
				end
			end
			m_data: begin
				if (xfer) begin
					if (is_read_ff) begin
						nxt_rv = 1'b1;
						nxt_rd = bus.ad_in;
					end
					if (!frame_ff) begin
						// Last phase done: release bus
						nxt_irdy = 1'b0;
						nxt_ad_oe = 1'b0;
						nxt_cbe = be_none_n;
						nxt_done = 1'b1;
						nxt_st = m_idle;
					end else begin
						nxt_left = left_ff - 1'b1;
						// Stop or last word: drop frame next phase
						if (left_ff == len_width'(1) || !bus.stop_n) begin
							nxt_frame = 1'b0;
						end
						if (!is_read_ff) begin
							nxt_irdy = wdata_valid;
							nxt_wr = wdata_valid;
							if (wdata_valid) begin
								nxt_ad = wdata;
							end
						end
					end
				end else if (!irdy_ff && wdata_valid && !is_read_ff) begin
					nxt_ad = wdata;
					nxt_irdy = 1'b1;
					nxt_wr = 1'b1;
				end else if (!bus.stop_n && frame_ff) begin
					nxt_frame = 1'b0;
				end
				// Otherwise hold everything: wait state
			end
			default: nxt_st = m_idle;
		endcase
		nxt_idle = nxt_st == m_idle;
	end
	// Registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_ff <= m_idle;
			ad_ff <= ad_reset;
			ad_oe_ff <= 1'b0;
			cbe_ff <= be_none_n;
			frame_ff <= 1'b0;
			irdy_ff <= 1'b0;
			is_read_ff <= 1'b0;
			left_ff <= '0;
			rv_ff <= 1'b0;
			rd_ff <= ad_reset;
			done_ff <= 1'b0;
			wr_ff <= 1'b0;
			idle_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			ad_ff <= nxt_ad;
			ad_oe_ff <= nxt_ad_oe;
			cbe_ff <= nxt_cbe;
			frame_ff <= nxt_frame;
			irdy_ff <= nxt_irdy;
			is_read_ff <= nxt_is_read;
			left_ff <= nxt_left;
			rv_ff <= nxt_rv;
			rd_ff <= nxt_rd;
			done_ff <= nxt_done;
			wr_ff <= nxt_wr;
			idle_ff <= nxt_idle;
		end
	end
	//////////////////////////////////////////////////////////////////
	// Parity follows AD by one clock; driven for address and writes
	always_comb begin
		nxt_par_oe = ad_oe_ff;
		nxt_par = ^{ad_ff, cbe_ff};
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			par_ff <= 1'b0;
			par_oe_ff <= 1'b0;
		end else begin
			par_ff <= nxt_par;
			par_oe_ff <= nxt_par_oe;
		end
	end
	assign bus.ad_m = ad_ff;
	assign bus.ad_m_oe = ad_oe_ff;
	assign bus.cbe_n = cbe_ff;
	assign bus.par_m = par_ff;
	assign bus.par_m_oe = par_oe_ff;
	assign bus.frame_n = !frame_ff;
	assign bus.irdy_n = !irdy_ff;
	assign cmd_ready = idle_ff;
	assign wdata_ready = wr_ff;
	assign rdata_valid = rv_ff;
	assign rdata = rd_ff;
	assign done = done_ff;
endmodule
`default_nettype wire

/* File: pci_link_asserts.sv */
// Checker for the bus wires between initiator and target ends.
// Assumes plain link signals on one clock, reset synchronous high.
`timescale 1ns/100ps
`default_nettype none
module pci_link_asserts (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [31:0] ad_m,
	input wire logic ad_m_oe,
	input wire logic [31:0] ad_t,
	input wire logic ad_t_oe,
	input wire logic [31:0] ad_in,
	input wire logic [3:0] cbe_n,
	input wire logic par_m,
	input wire logic par_m_oe,
	input wire logic par_t,
	input wire logic par_t_oe,
	input wire logic par_in,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic trdy_n,
	input wire logic stop_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	// Address phase is driven by the initiator alone
	a_addr_drive: assert property ($fell(frame_n) |-> ad_m_oe && !ad_t_oe)
		else $error("address phase not driven by initiator");
	a_irdy_next: assert property ($fell(frame_n) |=> !irdy_n)
		else $error("no data phase after address phase");
	// Ready strobes stay up with steady data through wait cycles
	a_wr_hold: assert property (!irdy_n && trdy_n && ad_m_oe |=> !irdy_n && $stable(ad_m))
		else $error("write data moved in wait cycle");
	a_rd_hold: assert property (!trdy_n && irdy_n && ad_t_oe |=> !trdy_n && $stable(ad_t))
		else $error("read data moved in wait cycle");
	a_be_hold: assert property (!irdy_n && trdy_n |=> $stable(cbe_n))
		else $error("byte enables moved in data phase");
	// Parity follows the lines one clock late, from the same owner
	a_par_master: assert property ($past(ad_m_oe) |->
		par_m_oe && (par_m == ^{$past(ad_m), $past(cbe_n)}))
		else $error("initiator parity wrong or late");
	a_par_target: assert property ($past(ad_t_oe) |->
		par_t_oe && (par_t == ^{$past(ad_t), $past(cbe_n)}))
		else $error("target parity wrong or late");
	a_one_driver: assert property (!(ad_m_oe && ad_t_oe) && !(par_m_oe && par_t_oe))
		else $error("both ends drive the bus");
	// Target ready on a read means the target is driving the lines
	a_rd_present: assert property (!trdy_n && !ad_m_oe |-> ad_t_oe)
		else $error("target ready without read data");
	// Whoever drives parity, the resolved lines come out even
	a_par_even: assert property (par_m_oe || par_t_oe |->
		^{par_in, $past(ad_in), $past(cbe_n)} == 1'b0)
		else $error("bus parity not even");
	// A stop request must end the transaction soon
	a_stop_ends: assert property ($fell(stop_n) |-> ##[1:20] frame_n && irdy_n)
		else $error("transaction not ended after stop");
endmodule
`default_nettype wire

/* File: testbench.sv */
// Testbench joining initiator and target across one link.
// Assumes the package constants and the hand-over timing.
`timescale 1ns/100ps
`default_nettype none
module testbench import pci_pkg::*; ;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [3:0] cmd_code = 4'h0;
	logic [31:0] cmd_addr = 32'h0;
	logic [7:0] cmd_len = 8'h0;
	logic [3:0] cmd_be = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wdata_valid = 1'b0;
	logic wr_ready = 1'b0;
	logic rd_valid = 1'b0;
	logic [31:0] rd_data = 32'h0;
	logic stop_req = 1'b0;
	logic cmd_ready, wdata_ready, rdata_valid, done, wr_valid, rd_ready;
	logic [31:0] rdata, wr_data, wr_addr;
	logic [3:0] wr_be;
	logic [31:0] ad_last = 32'h0; // Released lines show the inverse
	logic par_last = 1'b0;
	int num_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int rk = 0; // Read words seen by the user
	int n;
	////////////////////////////////////////////////////////////////
	pci_link pci_link_i ();
	assign pci_link_i.ad_in = pci_link_i.ad_m_oe ? pci_link_i.ad_m :
		pci_link_i.ad_t_oe ? pci_link_i.ad_t : ~ad_last;
	assign pci_link_i.par_in = pci_link_i.par_m_oe ? pci_link_i.par_m :
		pci_link_i.par_t_oe ? pci_link_i.par_t : ~par_last;
	pci_initiator #(.len_width(8)) pci_initiator_i (.mclk(mclk), .sys_rst(sys_rst),
		.bus(pci_link_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_be(cmd_be), .wdata(wdata),
		.wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .rdata_valid(rdata_valid),
		.rdata(rdata), .done(done));
	pci_target #(.depth(8)) pci_target_i (.mclk(mclk), .sys_rst(sys_rst), .bus(pci_link_i),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_be(wr_be),
		.wr_addr(wr_addr), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.stop_req(stop_req));
	pci_link_asserts pci_link_asserts_i (.mclk(mclk), .sys_rst(sys_rst),
		.ad_m(pci_link_i.ad_m), .ad_m_oe(pci_link_i.ad_m_oe), .ad_t(pci_link_i.ad_t),
		.ad_t_oe(pci_link_i.ad_t_oe), .ad_in(pci_link_i.ad_in), .cbe_n(pci_link_i.cbe_n),
		.par_m(pci_link_i.par_m), .par_m_oe(pci_link_i.par_m_oe), .par_t(pci_link_i.par_t),
		.par_t_oe(pci_link_i.par_t_oe), .par_in(pci_link_i.par_in),
		.frame_n(pci_link_i.frame_n), .irdy_n(pci_link_i.irdy_n),
		.trdy_n(pci_link_i.trdy_n), .stop_n(pci_link_i.stop_n));
	////////////////////////////////////////////////////////////////
	always #10 mclk = ~mclk;
	// Last bus levels, inverted while nobody drives
	always @(posedge mclk) begin
		ad_last <= pci_link_i.ad_in;
		par_last <= pci_link_i.par_in;
	end
	// Hang guard, far above the roughly 870 cycles needed
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			$display("unexpected %0t run did not finish", $time);
			summarize();
		end
	end
	function automatic logic [31:0] wpat(input int k);
		return 32'h5a000000 + 32'(k);
	endfunction
	function automatic logic [31:0] rpat(input int k);
		return 32'h77000000 + 32'(k);
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One burst: issue, feed, watch bus and user sides for 120 cycles
	task automatic run(input logic [3:0] code, input logic [31:0] addr, input logic [7:0] len,
		input logic [3:0] be, input int stop_at, output int xfers);
		int wk, wn, rb, i, nd;
		logic pf, wr, wseen;
		wk = 0;
		wn = 0;
		nd = 0;
		rb = rk;
		xfers = 0;
		pf = 1'b1;
		wr = code[0];
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_addr <= addr;
		cmd_len <= len;
		cmd_be <= be;
		wdata_valid <= wr;
		wdata <= wpat(0);
		@(posedge mclk);
		cmd_valid <= 1'b0;
		for (i = 0; i < 120; i++) begin
			@(negedge mclk);
			if (i == 0) check(cmd_ready, 1'b0);
			if (!pci_link_i.frame_n && pf) begin
				check(pci_link_i.ad_in, addr);
				check(pci_link_i.cbe_n, code);
			end
			pf = pci_link_i.frame_n;
			if (!pci_link_i.irdy_n && !pci_link_i.trdy_n) begin
				check(pci_link_i.cbe_n, {~be});
				check(pci_link_i.ad_in, wr ? wpat(xfers) : rpat(rb + xfers));
				xfers++;
			end
			if (wr_valid && wr_ready) begin
				check(wr_data, wpat(wk));
				check(wr_be, be);
				check(wr_addr, addr + 32'(4 * wk));
				wk++;
			end
			if (rdata_valid === 1'b1) begin
				check(rdata, rpat(rk));
				rk++;
			end
			nd += (done === 1'b1);
			wseen = wdata_ready;
			@(posedge mclk);
			if (wseen) begin
				wn++;
				wdata <= wpat(wn);
			end
			wr_ready <= (i % 3) != 0; // Far side stalls one cycle in three
			stop_req <= stop_at >= 0 && xfers > stop_at && nd == 0;
		end
		wdata_valid <= 1'b0; // Stop request already falls once done is seen
		check(nd, 1);
		check(cmd_ready, 1'b1);
		check(wk + rk - rb, xfers);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_writes();
		run(cmd_mem_write, 32'h1000, 8'h5, 4'hf, -1, n);
		check(n, 6);
		run(cmd_cfg_write, 32'h40, 8'h1, 4'h3, -1, n);
		check(n, 2);
		run(cmd_io_write, 32'h103, 8'h0, 4'h1, -1, n);
		check(n, 1);
		$display("test writes done");
	endtask
	// Read buffer fills until it refuses
	task automatic t_fill();
		@(posedge mclk);
		rd_valid <= 1'b1;
		rd_data <= rpat(0);
		n = 0;
		while (n < 12) begin
			@(negedge mclk);
			if (!rd_ready) break;
			n++;
			@(posedge mclk);
			rd_data <= rpat(n);
		end
		@(posedge mclk);
		rd_valid <= 1'b0;
		check(n, 8);
		$display("test fill done");
	endtask
	// Reads drain the buffer to empty
	task automatic t_reads();
		run(cmd_mem_read, 32'h2000, 8'h5, 4'hf, -1, n);
		check(n, 6);
		run(cmd_io_read, 32'h11, 8'h0, 4'h2, -1, n);
		check(n, 1);
		run(cmd_cfg_read, 32'h80, 8'h0, 4'hf, -1, n);
		check(rk, 8);
		check(rd_ready, 1'b1);
		$display("test reads done");
	endtask
	task automatic t_stop();
		run(cmd_mem_write, 32'h3000, 8'h7, 4'hf, 1, n);
		check(n < 8 && n >= 2, 1'b1);
		$display("test stop done");
	endtask
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		t_writes();
		t_fill();
		t_reads();
		t_stop();
		summarize();
	end
endmodule
`default_nettype wire
